// >>> dv/mrc_reset_source.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_reset_source (
    // Clock
    input  wire logic                  mclk,
    // Control from the bench
    input  wire logic                  pin_low,
    input  wire logic [7:0]            byte_lo,
    input  wire logic [7:0]            byte_hi,
    input  wire logic [1:0]            ack_dly,
    // Reset pin
    output var  logic                  ext_reset_n,
    // Vector memory
    input  wire mrc_pkg::mrc_vec_req_t vec_req,
    output var  logic                  vec_ack,
    output var  logic [7:0]            vec_data
);
    import mrc_pkg::*;

    logic       glitch_r;
    logic [1:0] wait_r;

    initial begin
        glitch_r = 1'b0;
        wait_r   = 2'h0;
        vec_ack  = 1'b0;
        vec_data = 8'h5a;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Low pulse placed between two rising edges so that no rising edge can sample it
    task automatic glitch();
        @(posedge mclk);
        #5 glitch_r = 1'b1;
        #10 glitch_r = 1'b0;
    endtask

    assign ext_reset_n = ~(pin_low | glitch_r);

    ////////////////////////////////////////////////////////////////////////////////
    // Vector bytes; the data lines toggle whenever no byte is being answered
    always @(posedge mclk) begin
        if (vec_ack) begin
            vec_ack  <= 1'b0;
            vec_data <= ~vec_data;
        end else if (vec_req.req && wait_r < ack_dly) begin
            wait_r   <= wait_r + 2'h1;
            vec_data <= ~vec_data;
        end else if (vec_req.req) begin
            wait_r   <= 2'h0;
            vec_ack  <= 1'b1;
            vec_data <= (vec_req.addr == 16'h0000) ? byte_lo : byte_hi;
        end else begin
            vec_data <= ~vec_data;
        end
    end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import mrc_pkg::*;

    logic          mclk, resetn, watchdog_overflow, power_on_clear_detector;
    logic          supply_below_lvi, stop_mode_req, ext_reset_n, vec_ack;
    logic          sys_reset_n, cpu_run, pc_valid, pin_oe_n, stop_hold, ram_retain;
    logic          pin_low, pv_q;
    logic [1:0]    ack_dly;
    logic [7:0]    vec_data, byte_lo, byte_hi, power_on_clear_flags, low_voltage_flags;
    logic [15:0]   program_counter;
    logic [31:0]   rnd;
    mrc_vec_req_t  vec_req;
    mrc_core_t     core_regs;
    mrc_timer_t    timer_regs;
    mrc_periph_t   periph_regs;
    logic [15:0]   exp_q[$];
    int            miscompares, cmp_count, cyc, n;
    bit            oe_bad;

    mrc_reset_ctrl DUT (.mclk(mclk), .resetn(resetn), .ext_reset_n(ext_reset_n),
        .watchdog_overflow(watchdog_overflow), .power_on_clear_detector(power_on_clear_detector),
        .supply_below_lvi(supply_below_lvi), .stop_mode_req(stop_mode_req), .vec_req(vec_req),
        .vec_ack(vec_ack), .vec_data(vec_data), .sys_reset_n(sys_reset_n), .cpu_run(cpu_run),
        .pc_valid(pc_valid), .program_counter(program_counter), .pin_oe_n(pin_oe_n),
        .stop_hold(stop_hold), .ram_retain(ram_retain), .core_regs(core_regs),
        .timer_regs(timer_regs), .periph_regs(periph_regs),
        .power_on_clear_flags(power_on_clear_flags), .low_voltage_flags(low_voltage_flags));

    mrc_reset_source partner (.mclk(mclk), .pin_low(pin_low), .byte_lo(byte_lo),
        .byte_hi(byte_hi), .ack_dly(ack_dly), .ext_reset_n(ext_reset_n), .vec_req(vec_req),
        .vec_ack(vec_ack), .vec_data(vec_data));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pc(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // New random vector bytes and answer delay; the expected start address is queued
    task automatic set_vec();
        @(posedge mclk);
        rnd = xs(rnd);
        byte_lo <= rnd[7:0];
        byte_hi <= rnd[15:8];
        ack_dly <= rnd[17:16];
        exp_q.push_back(rnd[15:0]);
    endtask

    // Counts cycles until the system leaves reset; pins must float meanwhile
    task automatic wait_run();
        n = 0;
        oe_bad = 1'b0;
        while (!(n >= 2 && sys_reset_n === 1'b1) && n < 33000) begin
            @(negedge mclk);
            n++;
            if (n >= 2 && sys_reset_n !== 1'b1 && pin_oe_n !== 1'b1)
                oe_bad = 1'b1;
        end
    endtask

    task automatic chk_rst_vals();
        chk(128'(core_regs), 128'(56'h0200ff00020004));
        chk(128'(timer_regs), 128'({16'h0000, 16'hffff, 64'h0}));
        chk(128'(periph_regs), 128'({32'h0, 8'hff, 8'h00, 8'hff, 16'h0}));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 101000) begin
            miscompares++;
            finish_test();
        end
    end

    // Each new start address is compared with the oldest queued expectation
    always @(negedge mclk) begin
        if (pc_valid === 1'b1 && pv_q !== 1'b1) begin
            if (exp_q.size() == 0)
                chk_pc(program_counter, ~program_counter);
            else
                chk_pc(program_counter, exp_q.pop_front());
        end
        pv_q = pc_valid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc = 0;
        miscompares = 0;
        cmp_count = 0;
        pv_q = 1'b0;
        rnd = 32'h00003578;
        resetn = 1'b0;
        watchdog_overflow = 1'b0;
        power_on_clear_detector = 1'b0;
        supply_below_lvi = 1'b0;
        stop_mode_req = 1'b0;
        pin_low = 1'b1;
        byte_lo = 8'h00;
        byte_hi = 8'h00;
        ack_dly = 2'h0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        // External pin reset
        repeat (400) @(posedge mclk);
        @(negedge mclk);
        chk({pin_oe_n, sys_reset_n, pc_valid}, 3'b100);
        chk_rst_vals();
        chk(power_on_clear_flags, 8'h00);
        set_vec();
        @(posedge mclk);
        pin_low <= 1'b0;
        wait_run();
        chk(n > 32766 && n < 32810, 1'b1);
        chk(oe_bad, 1'b0);
        repeat (12) @(negedge mclk);
        chk({cpu_run, pin_oe_n}, 2'b10);
        @(posedge mclk);
        supply_below_lvi <= 1'b1;
        repeat (3) @(negedge mclk);
        chk(low_voltage_flags, 8'h04);
        partner.glitch();
        @(posedge mclk);
        supply_below_lvi <= 1'b0;
        repeat (5) @(negedge mclk);
        chk({cpu_run, sys_reset_n}, 2'b11);
        // Pin reset in stop standby, overlapped by power-on clear
        @(posedge mclk);
        stop_mode_req <= 1'b1;
        set_vec();
        @(posedge mclk);
        pin_low <= 1'b1;
        repeat (4) @(negedge mclk);
        chk({stop_hold, pin_oe_n, sys_reset_n, pc_valid}, 4'b1100);
        chk_rst_vals();
        @(posedge mclk);
        power_on_clear_detector <= 1'b1;
        repeat (2) @(posedge mclk);
        pin_low <= 1'b0;
        repeat (100) @(negedge mclk);
        chk({sys_reset_n, pin_oe_n}, 2'b01);
        @(posedge mclk);
        power_on_clear_detector <= 1'b0;
        wait_run();
        chk(n > 32766 && n < 32810, 1'b1);
        chk(oe_bad, 1'b0);
        repeat (12) @(negedge mclk);
        chk({ram_retain, power_on_clear_flags}, 9'h104);
        @(posedge mclk);
        stop_mode_req <= 1'b0;
        // Watchdog overflow while running
        set_vec();
        @(posedge mclk);
        watchdog_overflow <= 1'b1;
        @(posedge mclk);
        watchdog_overflow <= 1'b0;
        repeat (2) @(negedge mclk);
        chk({pin_oe_n, sys_reset_n, pc_valid, cpu_run}, 4'b1000);
        chk_rst_vals();
        wait_run();
        chk(n > 32766 && n < 32810, 1'b1);
        chk(oe_bad, 1'b0);
        repeat (12) @(negedge mclk);
        chk({cpu_run, power_on_clear_flags}, 9'h104);
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule

`default_nettype wire

// >>> include/mrc_cfg.svh
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

// Clock and stabilization timing
`define MRC_CLK_NS          25
`define MRC_OSC_WAIT_EXP    15
`define MRC_OSC_WAIT_CYC    (32'h1 << `MRC_OSC_WAIT_EXP)
`define MRC_CNT_W           18
// Selection codes of the stabilization register
`define MRC_OSC_STABILIZATION_SELECT_2P12       3'h0
`define MRC_OSC_STABILIZATION_SELECT_2P15       3'h2
`define MRC_OSC_STABILIZATION_SELECT_2P17       3'h4
`define MRC_EXP_12          5'h0c
`define MRC_EXP_15          5'h0f
`define MRC_EXP_17          5'h11
// Reset vector addresses
`define MRC_VEC_LO_ADDR     16'h0000
`define MRC_VEC_HI_ADDR     16'h0001
// Reset values
`define MRC_PSW_RST         8'h02
`define MRC_PORT_LATCH_RST  8'h00
`define MRC_PORT_DIR_RST    8'hff
`define MRC_PULLUP_RST      8'h00
`define MRC_PCC_RST         8'h02
`define MRC_CMC_RST         8'h00
`define MRC_OSC_STABILIZATION_SELECT_RST        8'h04
`define MRC_WTMR_CNT_RST    16'h0000
`define MRC_WTMR_CMP_RST    16'hffff
`define MRC_BYTE_ZERO       8'h00
`define MRC_BYTE_ONES       8'hff
`define MRC_POC_FLAG_VAL    8'h04
`define MRC_LVI_FLAG_VAL    8'h04

`endif

// >>> include/mrc_pkg.sv
package mrc_pkg;

    typedef enum logic [1:0] {
        MRC_HOLD,
        MRC_WAIT,
        MRC_FETCH,
        MRC_RUN
    } mrc_state_t;

    typedef struct packed {
        logic [7:0] program_status_word;
        logic [7:0] port_latch;
        logic [7:0] port0_direction;
        logic [7:0] port0_pullup_option;
        logic [7:0] processor_clock_control;
        logic [7:0] clock_multiplier_control;
        logic [7:0] osc_stabilization_select;
    } mrc_core_t;

    typedef struct packed {
        logic [15:0] wide_timer_count;
        logic [15:0] wide_timer_compare;
        logic [7:0]  wide_timer_control;
        logic [7:0]  narrow_timer_count;
        logic [7:0]  narrow_timer_mode;
        logic [7:0]  carrier_output_control;
        logic [7:0]  remote_signal_control;
        logic [7:0]  narrow_timer_source_clock;
        logic [7:0]  watchdog_clock_select;
        logic [7:0]  watchdog_mode_reg;
    } mrc_timer_t;

    typedef struct packed {
        logic [7:0] sync_serial_mode;
        logic [7:0] async_serial_mode;
        logic [7:0] async_serial_status;
        logic [7:0] baud_rate_control;
        logic [7:0] transmit_shift_reg;
        logic [7:0] interrupt_request_flags;
        logic [7:0] interrupt_mask_flags;
        logic [7:0] external_interrupt_mode;
        logic [7:0] key_return_mode;
    } mrc_periph_t;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } mrc_vec_req_t;

endpackage

// >>> rtl/mrc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrc_cfg.svh"

module mrc_reset_ctrl (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Reset sources and low-voltage detect input
    input  wire logic                 ext_reset_n,
    input  wire logic                 watchdog_overflow,
    input  wire logic                 power_on_clear_detector,
    input  wire logic                 supply_below_lvi,
    // Standby status from the core
    input  wire logic                 stop_mode_req,
    // Reset vector fetch
    output mrc_pkg::mrc_vec_req_t     vec_req,
    input  wire logic                 vec_ack,
    input  wire logic [7:0]           vec_data,
    // Core outputs
    output var  logic                 sys_reset_n,
    output var  logic                 cpu_run,
    output var  logic                 pc_valid,
    output var  logic [15:0]          program_counter,
    output var  logic                 pin_oe_n,
    output var  logic                 stop_hold,
    output var  logic                 ram_retain,
    output mrc_pkg::mrc_core_t        core_regs,
    output mrc_pkg::mrc_timer_t       timer_regs,
    output mrc_pkg::mrc_periph_t      periph_regs,
    output var  logic [7:0]           power_on_clear_flags,
    output var  logic [7:0]           low_voltage_flags
);
    import mrc_pkg::*;

    localparam logic [`MRC_CNT_W-1:0] WAIT_CYC = `MRC_CNT_W'(`MRC_OSC_WAIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Source merge

    logic ext_n_s;
    logic reset_req;
    mrc_state_t state_r;
    mrc_state_t state_nxt;
    logic cnt_clear;
    logic cnt_done;
    logic vec_phase_r;
    logic [7:0] vec_lo_r;
    logic poc_seen_r;
    logic stop_r;

    mrc_sync u_ext_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (ext_reset_n),
        .dout   (ext_n_s)
    );

    // Pin, watchdog or power-on clear forces the one common reset state; supply_below_lvi does not
    assign reset_req = !ext_n_s || watchdog_overflow || power_on_clear_detector;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MRC_HOLD:  if (!reset_req) state_nxt = MRC_WAIT;
            MRC_WAIT:  if (cnt_done) state_nxt = MRC_FETCH;
            MRC_FETCH: if (vec_ack && vec_phase_r) state_nxt = MRC_RUN;
            MRC_RUN:   state_nxt = MRC_RUN;
            default:   state_nxt = MRC_HOLD;
        endcase
        if (reset_req) state_nxt = MRC_HOLD;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= MRC_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cnt_clear = (state_r != MRC_WAIT);

    mrc_wait_counter u_wait (
        .mclk   (mclk),
        .resetn (resetn),
        .clear  (cnt_clear),
        .limit  (WAIT_CYC),
        .done   (cnt_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Vector fetch

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vec_phase_r <= 1'b0;
            vec_lo_r    <= `MRC_BYTE_ZERO;
        end else if (state_r != MRC_FETCH) begin
            vec_phase_r <= 1'b0;
        end else if (vec_ack && !vec_phase_r) begin
            vec_lo_r    <= vec_data;
            vec_phase_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vec_req <= '0;
        end else begin
            vec_req.req  <= (state_nxt == MRC_FETCH);
            vec_req.addr <= (state_nxt == MRC_FETCH && (vec_phase_r || vec_ack)
                             && state_r == MRC_FETCH)
                            ? `MRC_VEC_HI_ADDR : `MRC_VEC_LO_ADDR;
        end
    end

    // Counter is zero after resetn, else keeps its old value (undefined to software), until the vector lands
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            program_counter <= `MRC_WTMR_CNT_RST;
            pc_valid        <= 1'b0;
        end else if (reset_req) begin
            pc_valid        <= 1'b0;
        end else if (state_r == MRC_FETCH && vec_ack && vec_phase_r) begin
            program_counter <= {vec_data, vec_lo_r};
            pc_valid        <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and run control

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sys_reset_n <= 1'b0;
            cpu_run     <= 1'b0;
            pin_oe_n    <= 1'b1;
        end else begin
            sys_reset_n <= (state_nxt == MRC_FETCH) || (state_nxt == MRC_RUN);
            cpu_run     <= (state_nxt == MRC_RUN);
            pin_oe_n    <= (state_nxt == MRC_HOLD) || (state_nxt == MRC_WAIT);
        end
    end

    // Stop state kept while reset is held; RAM retained on standby exit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stop_r     <= 1'b0;
            stop_hold  <= 1'b0;
            ram_retain <= 1'b0;
        end else begin
            if (state_r == MRC_RUN && !reset_req) begin
                stop_r <= stop_mode_req;
            end else if (state_nxt == MRC_FETCH) begin
                stop_r <= 1'b0;
            end
            stop_hold <= stop_r && (state_nxt == MRC_HOLD);
            if (reset_req && state_r == MRC_RUN) begin
                ram_retain <= stop_mode_req;
            end else if (reset_req && stop_r) begin
                ram_retain <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reset values

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            core_regs <= '0;
        end else if (reset_req || state_r != MRC_RUN) begin
            core_regs.program_status_word      <= `MRC_PSW_RST;
            core_regs.port_latch               <= `MRC_PORT_LATCH_RST;
            core_regs.port0_direction          <= `MRC_PORT_DIR_RST;
            core_regs.port0_pullup_option      <= `MRC_PULLUP_RST;
            core_regs.processor_clock_control  <= `MRC_PCC_RST;
            core_regs.clock_multiplier_control <= `MRC_CMC_RST;
            core_regs.osc_stabilization_select <= `MRC_OSC_STABILIZATION_SELECT_RST;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timer_regs <= '0;
        end else if (reset_req || state_r != MRC_RUN) begin
            timer_regs.wide_timer_count          <= `MRC_WTMR_CNT_RST;
            timer_regs.wide_timer_compare        <= `MRC_WTMR_CMP_RST;
            timer_regs.wide_timer_control        <= `MRC_BYTE_ZERO;
            timer_regs.narrow_timer_count        <= `MRC_BYTE_ZERO;
            timer_regs.narrow_timer_mode         <= `MRC_BYTE_ZERO;
            timer_regs.carrier_output_control    <= `MRC_BYTE_ZERO;
            timer_regs.remote_signal_control     <= `MRC_BYTE_ZERO;
            timer_regs.narrow_timer_source_clock <= `MRC_BYTE_ZERO;
            timer_regs.watchdog_clock_select     <= `MRC_BYTE_ZERO;
            timer_regs.watchdog_mode_reg         <= `MRC_BYTE_ZERO;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            periph_regs <= '0;
        end else if (reset_req || state_r != MRC_RUN) begin
            periph_regs.sync_serial_mode        <= `MRC_BYTE_ZERO;
            periph_regs.async_serial_mode       <= `MRC_BYTE_ZERO;
            periph_regs.async_serial_status     <= `MRC_BYTE_ZERO;
            periph_regs.baud_rate_control       <= `MRC_BYTE_ZERO;
            periph_regs.transmit_shift_reg      <= `MRC_BYTE_ONES;
            periph_regs.interrupt_request_flags <= `MRC_BYTE_ZERO;
            periph_regs.interrupt_mask_flags    <= `MRC_BYTE_ONES;
            periph_regs.external_interrupt_mode <= `MRC_BYTE_ZERO;
            periph_regs.key_return_mode         <= `MRC_BYTE_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cause flags

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            poc_seen_r           <= 1'b0;
            power_on_clear_flags <= `MRC_BYTE_ZERO;
            low_voltage_flags    <= `MRC_BYTE_ZERO;
        end else begin
            if (power_on_clear_detector) begin
                poc_seen_r <= 1'b1;
            end else if (state_r == MRC_RUN) begin
                poc_seen_r <= 1'b0;
            end
            if (power_on_clear_detector) begin
                power_on_clear_flags <= `MRC_POC_FLAG_VAL;
            end else if (reset_req && !poc_seen_r) begin
                power_on_clear_flags <= power_on_clear_flags;
            end
            if (supply_below_lvi) begin
                low_voltage_flags <= `MRC_LVI_FLAG_VAL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence release_s;
        (state_r == MRC_HOLD) ##1 (state_r == MRC_WAIT);
    endsequence

    logic [`MRC_CNT_W-1:0] wait_seen_r;

    // Cycles spent in the wait, counted apart from the wait counter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_seen_r <= '0;
        end else if (state_r == MRC_WAIT) begin
            wait_seen_r <= wait_seen_r + 1'b1;
        end else begin
            wait_seen_r <= '0;
        end
    end

    reg_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
        power_on_clear_detector |=> state_r == MRC_HOLD)
        else $error("reset source did not hold");
    hiz_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_HOLD || state_r == MRC_WAIT) |-> pin_oe_n)
        else $error("pins driven during reset or wait");
    wait_len_a: assert property (@(posedge mclk) disable iff (!resetn)
        release_s ##1 (!reset_req) [*8] |-> state_r == MRC_WAIT)
        else $error("wait ended early");
    psw_val_a: assert property (@(posedge mclk) disable iff (!resetn)
        reset_req |=> core_regs.program_status_word == `MRC_PSW_RST)
        else $error("status word not 02H");
    mask_val_a: assert property (@(posedge mclk) disable iff (!resetn)
        reset_req |=> periph_regs.interrupt_mask_flags == `MRC_BYTE_ONES)
        else $error("masks not set");
    pc_undef_a: assert property (@(posedge mclk) disable iff (!resetn)
        reset_req |=> !pc_valid)
        else $error("pc valid in reset");
    poc_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
        power_on_clear_detector |=> power_on_clear_flags == `MRC_POC_FLAG_VAL)
        else $error("poc flag missing");
    run_vec_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(cpu_run) |-> pc_valid)
        else $error("run without vector");
    stop_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        (stop_r && state_r == MRC_HOLD && reset_req) |=> stop_r)
        else $error("stop lost in reset");
    stop_hiz_a: assert property (@(posedge mclk) disable iff (!resetn)
        stop_hold |-> pin_oe_n)
        else $error("pins driven while stop held");
    fetch_req_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_FETCH) |-> vec_req.req)
        else $error("no vector request during fetch");
    lo_addr_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_FETCH && !vec_phase_r) |-> vec_req.addr == `MRC_VEC_LO_ADDR)
        else $error("first fetch not at low vector byte");
    hi_addr_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_FETCH && vec_phase_r) |-> vec_req.addr == `MRC_VEC_HI_ADDR)
        else $error("second fetch not at high vector byte");
    run_pins_a: assert property (@(posedge mclk) disable iff (!resetn)
        cpu_run |-> (sys_reset_n && !pin_oe_n))
        else $error("running while held in reset");
    pc_run_a: assert property (@(posedge mclk) disable iff (!resetn)
        pc_valid |-> cpu_run)
        else $error("pc valid while not running");
    dir_val_a: assert property (@(posedge mclk) disable iff (!resetn)
        reset_req |=> core_regs.port0_direction == `MRC_PORT_DIR_RST)
        else $error("port directions not all inputs");
    lvi_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
        supply_below_lvi |=> low_voltage_flags == `MRC_LVI_FLAG_VAL)
        else $error("low voltage flag missing");
    wait_end_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_WAIT && state_nxt == MRC_FETCH) |-> wait_seen_r == WAIT_CYC)
        else $error("wait length wrong");
    wait_max_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_r == MRC_WAIT) |-> wait_seen_r <= WAIT_CYC)
        else $error("wait overran");

endmodule

`default_nettype wire

// >>> rtl/mrc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Asynchronous level in, synchronised level out
    input  wire logic din,
    output var  logic dout
);

    logic meta_r;

    // First stage feeds the second stage only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/mrc_wait_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrc_cfg.svh"

module mrc_wait_counter (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Control
    input  wire logic                  clear,
    input  wire logic [`MRC_CNT_W-1:0] limit,
    // Status
    output var  logic                  done
);

    logic [`MRC_CNT_W-1:0] cnt_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (clear) begin
            cnt_r <= '0;
        end else if (cnt_r != limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign done = (cnt_r == limit) && !clear;

endmodule

`default_nettype wire
